// ---- src/dsga_arbiter.sv ----
// D-channel stop/go arbiter at the network termination side.
// How it works
// - Access request bit 1 gives stop_go_bit 1 in the next frame.
// - On request falling to 0, upstream D-channel forced zero, stop held.
// - With request 0, stop/go follows last message after go_delay.
// - Zeros continue after go until terminal HDLC data appears.
// - First zero bit of terminal frame restores transparent D-channel.
// - Monitor message code 25 hex forces the stop condition.
// - Stop/go taken from messages at most once per 6 ms slot.
// - Message transfer delay may reach 12 ms worst case.
// - go_delay is at least 7.5 ms.
// - Bypass setting leaves D-channel untouched; stop/go control continues.
`timescale 1ns/100ps
`include "dsga_regs.svh"
module dsga_arbiter #(
  parameter int GO_DELAY_CYC = `DSGA_GO_DELAY_CYC,
  parameter int MSG_SLOT_CYC = `DSGA_MSG_SLOT_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic frame_strobe,
  input wire logic access_request_bit,
  input wire logic d_up_valid,
  input wire logic d_up_in,
  output logic d_up_ready,
  output logic d_out_valid,
  input wire logic d_out_ready,
  output logic d_out_data,
  input wire logic msg_valid,
  input wire logic [7:0] msg_code,
  input wire logic block_select,
  input wire logic stop_go_local,
  input wire logic ignore_access_request,
  output logic stop_go_bit,
  output logic [1:0] arb_state
);
  localparam int GO_MIN_CYC = `DSGA_GO_MIN_CYC;
  localparam int EOC_XFER_CYC = `DSGA_EOC_XFER_CYC;

  dsga_pkg::dsga_arb_t cur_q;
  dsga_pkg::dsga_arb_t nxt_d;
  logic bypass;
  logic push;
  logic push_bit;
  logic fifo_ready;
  logic msg_take;
  logic slot_end;

  // The three bypass settings together leave the D-channel alone.
  assign bypass = !block_select && stop_go_local && ignore_access_request;

  // Zero forcing is skipped under bypass, so flag fill passes intact.
  assign push_bit = (cur_q.zero_gate && !bypass) ? 1'b0 : d_up_in;
  assign push = d_up_valid && fifo_ready;
  assign d_up_ready = fifo_ready;
  assign slot_end = (cur_q.slot_cnt == '0);
  // Only the first message of a slot is taken; later ones in that slot are ignored.
  assign msg_take = msg_valid && !cur_q.slot_used;
  assign stop_go_bit = cur_q.stop_go;
  assign arb_state = cur_q.st;

  // Upstream D-channel bits queue here; a stalled sink stalls the terminal.
  dsga_fifo #(
    .WIDTH(`DSGA_FIFO_WIDTH),
    .DEPTH(`DSGA_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .in_valid(d_up_valid),
    .in_ready(fifo_ready),
    .in_data(push_bit),
    .out_valid(d_out_valid),
    .out_ready(d_out_ready),
    .out_data(d_out_data)
  );

  // Next-state logic of the whole arbiter.
  always_comb begin
    nxt_d = cur_q;
    // Two-stage synchroniser on the pin-borne request bit.
    nxt_d.bac_meta = access_request_bit;
    nxt_d.bac_sync = cur_q.bac_meta;

    // Message slot timer; one message per slot keeps the 6 ms pacing.
    if (slot_end) begin
      nxt_d.slot_cnt = 20'(MSG_SLOT_CYC - 1);
      nxt_d.slot_used = 1'b0;
    end else begin
      nxt_d.slot_cnt = cur_q.slot_cnt - 20'h00001;
    end
    // A taken message is kept until the next one, so a late message within
    // the transfer delay still lands on the output.
    if (msg_take) begin
      nxt_d.slot_used = 1'b1;
      nxt_d.msg_stop = (msg_code == `DSGA_MON_STOP_CODE);
    end

    // go_delay runs every cycle once started.
    if (cur_q.st == dsga_pkg::DSGA_ST_WAIT) begin
      nxt_d.wait_cyc = cur_q.wait_cyc + 21'h000001;
      if (cur_q.go_cnt == '0) begin
        nxt_d.st = dsga_pkg::DSGA_ST_GO;
      end else begin
        nxt_d.go_cnt = cur_q.go_cnt - 21'h000001;
      end
    end

    // Terminal's first zero ends forcing; ones are treated as idle fill.
    if (cur_q.st == dsga_pkg::DSGA_ST_GO && push && !d_up_in) begin
      nxt_d.zero_gate = 1'b0;
    end

    // Frame boundary: latch the request of the last complete frame.
    if (frame_strobe) begin
      nxt_d.bac_frame = cur_q.bac_sync;
      if (cur_q.bac_sync) begin
        nxt_d.st = dsga_pkg::DSGA_ST_STOP;
        nxt_d.zero_gate = 1'b0;
        nxt_d.stop_go = 1'b1;
      end else begin
        if (cur_q.st == dsga_pkg::DSGA_ST_STOP) begin
          nxt_d.st = dsga_pkg::DSGA_ST_WAIT;
          nxt_d.go_cnt = 21'(GO_DELAY_CYC - 1);
          nxt_d.wait_cyc = '0;
          nxt_d.zero_gate = 1'b1;
        end
        // Stop is held until go_delay expires, then messages rule.
        if (cur_q.st == dsga_pkg::DSGA_ST_GO) begin
          nxt_d.stop_go = cur_q.msg_stop;
        end else begin
          nxt_d.stop_go = 1'b1;
        end
      end
    end
  end

  // State register; the terminal starts idle with stop shown.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_q <= '{bac_meta: 1'b1, bac_sync: 1'b1, bac_frame: 1'b1,
                 st: dsga_pkg::DSGA_ST_STOP, go_cnt: '0, slot_cnt: '0,
                 slot_used: 1'b0, msg_stop: 1'b1, stop_go: 1'b1,
                 zero_gate: 1'b0, wait_cyc: '0};
    end else if (clk_en) begin
      cur_q <= nxt_d;
    end
  end

  // Request seen at a frame boundary shows stop on the next cycle.
  a_stop_on_request: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && frame_strobe && cur_q.bac_sync) |=> stop_go_bit)
    else $error("Stop not shown after request bit 1.");

  // An idle request latched for the frame always shows stop.
  a_frame_req_stop: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    cur_q.bac_frame |-> stop_go_bit)
    else $error("Latched idle request without stop.");

  // While waiting out go_delay, stop is shown and, outside bypass, bits are forced low.
  a_wait_holds_stop: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (cur_q.st == dsga_pkg::DSGA_ST_WAIT && !bypass && d_up_valid)
      |-> (stop_go_bit && !push_bit))
    else $error("Wait phase did not hold stop with zero data.");

  // In go phase a frame boundary copies the last message to the output.
  a_go_follows_msg: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && frame_strobe && !cur_q.bac_sync
      && cur_q.st == dsga_pkg::DSGA_ST_GO)
      |=> (stop_go_bit == $past(cur_q.msg_stop)))
    else $error("Stop/go did not follow the last message.");

  // Ones from the terminal keep the forcing in place.
  a_hold_zero_gate: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && !frame_strobe && cur_q.st == dsga_pkg::DSGA_ST_GO
      && cur_q.zero_gate && push && d_up_in) |=> cur_q.zero_gate)
    else $error("Zero forcing ended without a zero bit.");

  // The first zero bit releases the channel.
  a_zero_releases: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && cur_q.st == dsga_pkg::DSGA_ST_GO && push && !d_up_in)
      |=> !cur_q.zero_gate)
    else $error("Channel not released on first zero.");

  // The stop monitor code leaves the stored message at stop.
  a_monitor_stop: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && msg_take && msg_code == `DSGA_MON_STOP_CODE) |=> cur_q.msg_stop)
    else $error("Stop code not stored.");

  // A message in the cycle right after a taken one, within the same slot, is never taken.
  a_one_msg_slot: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (clk_en && msg_take && !slot_end) |=> !msg_take)
    else $error("Two messages taken in one slot.");

  // Go phase comes exactly go_delay after the wait began, and not before the
  // least go_delay unless go_delay is set below it; the wait counter runs apart from the down counter.
  a_go_min_delay: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (cur_q.st == dsga_pkg::DSGA_ST_WAIT ##1
      cur_q.st == dsga_pkg::DSGA_ST_GO)
      |-> (cur_q.wait_cyc == 21'(GO_DELAY_CYC)
        && (GO_DELAY_CYC < GO_MIN_CYC
          || cur_q.wait_cyc >= 21'(GO_MIN_CYC - 1))))
    else $error("Go phase entered at the wrong time.");

  // Under bypass the upstream bit passes unchanged.
  a_bypass_clean: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (bypass && d_up_valid) |-> (push_bit == d_up_in))
    else $error("Bypass altered the D-channel.");

  // A message waits at most one slot, so wait plus transfer stays in budget.
  a_slot_in_budget: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (32'(cur_q.slot_cnt) < 32'(MSG_SLOT_CYC)
      && 2 * MSG_SLOT_CYC <= EOC_XFER_CYC))
    else $error("Slot timer beyond one slot.");

endmodule : dsga_arbiter

// ---- shared/dsga_regs.svh ----
// Timing counts and code values for the D-channel stop/go arbiter.
`ifndef DSGA_REGS_SVH
`define DSGA_REGS_SVH

// System clock period in nanoseconds (100 MHz).
`define DSGA_CLK_PERIOD_NS 10
// Fixed part of go_delay, in microseconds.
`define DSGA_GO_BASE_US 1500
// One embedded operations channel message frame, in microseconds.
`define DSGA_MSG_FRAME_US 6000
// Worst case message transfer delay, in microseconds.
`define DSGA_EOC_XFER_US 12000
// Least go_delay, in microseconds.
`define DSGA_GO_MIN_US 7500
// go_delay in cycles: base time plus two message frames.
`define DSGA_GO_DELAY_CYC \
  (((`DSGA_GO_BASE_US + 2 * `DSGA_MSG_FRAME_US) * 1000) / `DSGA_CLK_PERIOD_NS)
// Message slot length in cycles.
`define DSGA_MSG_SLOT_CYC ((`DSGA_MSG_FRAME_US * 1000) / `DSGA_CLK_PERIOD_NS)
// Worst case transfer delay in cycles.
`define DSGA_EOC_XFER_CYC ((`DSGA_EOC_XFER_US * 1000) / `DSGA_CLK_PERIOD_NS)
// Least go_delay in cycles.
`define DSGA_GO_MIN_CYC ((`DSGA_GO_MIN_US * 1000) / `DSGA_CLK_PERIOD_NS)
// Monitor message code that forces the stop condition.
`define DSGA_MON_STOP_CODE 8'h25
// Data FIFO shape.
`define DSGA_FIFO_WIDTH 1
`define DSGA_FIFO_DEPTH 8

`endif

// ---- shared/dsga_pkg.sv ----
// Types shared by the D-channel stop/go arbiter files.
package dsga_pkg;

  // Arbitration phase of the upstream D-channel.
  typedef enum logic [1:0] {
    DSGA_ST_STOP = 2'b00,
    DSGA_ST_WAIT = 2'b01,
    DSGA_ST_GO = 2'b10
  } dsga_state_t;

  // Complete register state of the arbiter.
  typedef struct packed {
    logic bac_meta;
    logic bac_sync;
    logic bac_frame;
    dsga_state_t st;
    logic [20:0] go_cnt;
    logic [19:0] slot_cnt;
    logic slot_used;
    logic msg_stop;
    logic stop_go;
    logic zero_gate;
    logic [20:0] wait_cyc;
  } dsga_arb_t;

endpackage : dsga_pkg

// ---- src/dsga_fifo.sv ----
// Small flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module dsga_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } dsga_fifo_t;

  dsga_fifo_t cur_q;
  dsga_fifo_t nxt_d;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (cur_q.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (cur_q.cnt != '0);
  assign out_data = cur_q.mem[cur_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at DEPTH so that depths other than powers of two work.
  always_comb begin
    nxt_d = cur_q;
    if (push) begin
      nxt_d.mem[cur_q.wr] = in_data;
      nxt_d.wr = (cur_q.wr == AW'(DEPTH - 1)) ? '0 : cur_q.wr + 1'b1;
    end
    if (pop) begin
      nxt_d.rd = (cur_q.rd == AW'(DEPTH - 1)) ? '0 : cur_q.rd + 1'b1;
    end
    nxt_d.cnt = cur_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_q <= '0;
    end else if (clk_en) begin
      cur_q <= nxt_d;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge sys_clk) disable iff (!resetn)
    cur_q.cnt <= (AW + 1)'(DEPTH))
    else $error("FIFO count above depth.");

endmodule : dsga_fifo

// ---- tb/dsga_term_model.sv ----
// Terminal layer-2 controller model on the upstream serial side.
`timescale 1ns/100ps
module dsga_term_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic want,
  input wire logic stop_go_bit,
  input wire logic d_up_ready,
  output logic access_request_bit,
  output logic d_up_valid,
  output logic d_up_in
);
  // Frame bits, first bit in the top place; two leading ones are idle.
  localparam logic [7:0] FRAME_BITS = 8'hD7;
  logic [3:0] idx_q;

  // Asks for access, waits for go, sends one frame, then gives up access.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      access_request_bit <= 1'b1;
      d_up_valid <= 1'b0;
      d_up_in <= 1'b0;
      idx_q <= 4'h0;
    end else if (d_up_valid && !d_up_ready) begin
      // A refused bit is held until the buffer takes it.
    end else if (idx_q == 4'h0) begin
      if (want) begin
        access_request_bit <= 1'b0;
        idx_q <= 4'h1;
      end
    end else if (idx_q <= 4'h8 && (!stop_go_bit || d_up_valid)) begin
      d_up_valid <= 1'b1;
      d_up_in <= FRAME_BITS[4'h8 - idx_q];
      idx_q <= idx_q + 4'h1;
    end else if (idx_q == 4'h1 && !want) begin
      access_request_bit <= 1'b1;
      idx_q <= 4'h0;
    end else if (idx_q == 4'h9) begin
      // Released line shows the inverse so a stale bit is never trusted.
      d_up_valid <= 1'b0;
      d_up_in <= ~d_up_in;
      access_request_bit <= 1'b1;
      idx_q <= 4'hA;
    end else if (idx_q == 4'hA && !want) begin
      idx_q <= 4'h0;
    end
  end
endmodule : dsga_term_model

// ---- tb/testbench.sv ----
// Self-checking testbench for the D-channel stop/go arbiter.
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic frame_strobe = 1'b0;
  logic msg_valid = 1'b0;
  logic [7:0] msg_code = 8'h00;
  logic d_out_ready = 1'b0;
  logic want = 1'b0;
  logic block_select = 1'b1;
  logic stop_go_local = 1'b0;
  logic ignore_access_request = 1'b0;
  logic access_request_bit, d_up_valid, d_up_in, d_up_ready;
  logic d_out_valid, d_out_data, stop_go_bit;
  logic [1:0] arb_state;
  logic [2:0] fcnt = 3'h0;
  logic [7:0] got;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int k;

  always #5 sys_clk = ~sys_clk;

  // Frame strobe every eight cycles; the cycle ceiling cuts a hang short.
  always @(posedge sys_clk) begin
    fcnt <= fcnt + 3'h1;
    frame_strobe <= (fcnt == 3'h6);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  dsga_arbiter #(.GO_DELAY_CYC(40), .MSG_SLOT_CYC(20)) dsga_arbiter_i (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1),
    .frame_strobe(frame_strobe), .access_request_bit(access_request_bit),
    .d_up_valid(d_up_valid), .d_up_in(d_up_in), .d_up_ready(d_up_ready),
    .d_out_valid(d_out_valid), .d_out_ready(d_out_ready),
    .d_out_data(d_out_data), .msg_valid(msg_valid), .msg_code(msg_code),
    .block_select(block_select), .stop_go_local(stop_go_local),
    .ignore_access_request(ignore_access_request), .stop_go_bit(stop_go_bit),
    .arb_state(arb_state));

  dsga_term_model dsga_term_model_i (
    .sys_clk(sys_clk), .resetn(resetn), .want(want),
    .stop_go_bit(stop_go_bit), .d_up_ready(d_up_ready),
    .access_request_bit(access_request_bit), .d_up_valid(d_up_valid),
    .d_up_in(d_up_in));

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic send_msg(logic [7:0] code);
    @(posedge sys_clk);
    msg_valid <= 1'b1;
    msg_code <= code;
    @(posedge sys_clk);
    msg_valid <= 1'b0;
  endtask : send_msg

  // Waits a bounded time for a state and reports how long it took.
  task automatic wait_state(logic [1:0] s, output int n);
    n = 0;
    while (arb_state !== s && n < 300) begin
      tick(1);
      n++;
    end
    check("arb_state", arb_state, s);
  endtask : wait_state

  // Pops eight bits one at a time, first bit into the top place.
  task automatic drain(output logic [7:0] v);
    int i;
    int w;
    for (i = 0; i < 8; i++) begin
      w = 0;
      while (d_out_valid !== 1'b1 && w < 50) begin
        tick(1);
        w++;
      end
      v = {v[6:0], d_out_data};
      @(posedge sys_clk);
      d_out_ready <= 1'b1;
      @(posedge sys_clk);
      d_out_ready <= 1'b0;
      #1;
    end
  endtask : drain

  task automatic close_out();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // Main sequence: a granted frame, a refused grant, then a granted frame under bypass.
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    tick(1);
    check("stop_go_bit", stop_go_bit, 1'b1);
    check("d_up_ready", d_up_ready, 1'b1);
    send_msg(8'h00);
    @(posedge sys_clk);
    want <= 1'b1;
    wait_state(2'b01, k);
    check("stop_go_bit", stop_go_bit, 1'b1);
    wait_state(2'b10, k);
    check("go_delay", (k >= 38 && k <= 42), 1'b1);
    tick(10);
    check("stop_go_bit", stop_go_bit, 1'b0);
    // The sink stalls so the eight frame bits fill the buffer.
    tick(30);
    check("d_up_ready", d_up_ready, 1'b0);
    check("stop_go_bit", stop_go_bit, 1'b1);
    check("arb_state", arb_state, 2'b00);
    drain(got);
    check("d_out_frame", got, 8'h17);
    check("d_out_valid", d_out_valid, 1'b0);
    @(posedge sys_clk);
    want <= 1'b0;
    tick(30);
    // A stop message, then a go in the same slot that must be ignored.
    send_msg(8'h25);
    send_msg(8'h00);
    @(posedge sys_clk);
    want <= 1'b1;
    wait_state(2'b10, k);
    tick(16);
    check("stop_go_bit", stop_go_bit, 1'b1);
    check("d_out_valid", d_out_valid, 1'b0);
    @(posedge sys_clk);
    want <= 1'b0;
    tick(20);
    check("arb_state", arb_state, 2'b00);
    // Bypass: the frame passes untouched while stop/go control goes on.
    @(posedge sys_clk);
    block_select <= 1'b0;
    stop_go_local <= 1'b1;
    ignore_access_request <= 1'b1;
    send_msg(8'h00);
    @(posedge sys_clk);
    want <= 1'b1;
    wait_state(2'b10, k);
    tick(10);
    check("stop_go_bit", stop_go_bit, 1'b0);
    tick(20);
    check("stop_go_bit", stop_go_bit, 1'b1);
    drain(got);
    check("d_out_frame", got, 8'hD7);
    @(posedge sys_clk);
    want <= 1'b0;
    block_select <= 1'b1;
    stop_go_local <= 1'b0;
    ignore_access_request <= 1'b0;
    tick(20);
    check("arb_state", arb_state, 2'b00);
    close_out();
  end
endmodule : testbench
